// File: flash_status_and_nv_config_regs_tb_top.sv
// Self-checking bench joining the controller end and the flash end over one link.
module flash_status_and_nv_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fsr_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic valid = 1'b0;
    logic [7:0] op = 8'h00;
    logic [2:0] txl = 3'h0;
    logic [31:0] txd = 32'h0;
    logic [1:0] rxl = 2'h0;
    logic wp = 1'b1;
    logic ready, done, xip_en, dflt, hold;
    logic acc, refd;
    logic [15:0] rx, nv;
    logic [7:0] st;
    logic [3:0] dum;
    logic [2:0] xmode, drv;
    fsr_proto_e proto;
    int num_errors = 0;
    int checks_done = 0;
    int acc_cnt = 0;
    int ref_cnt = 0;

    fsr_link_if u_fsr_link_if ();
    fsr_host u_fsr_host (.CLK_I(clk), .RESETN_I(rst_n), .CMD_VALID_I(valid), .CMD_OP_I(op),
        .CMD_TXLEN_I(txl), .CMD_TXDATA_I(txd), .CMD_RXLEN_I(rxl), .WP_LEVEL_I(wp),
        .CMD_READY_O(ready), .DONE_O(done), .RX_DATA_O(rx), .LINK(u_fsr_link_if));
    fsr_device #(.BUSY_CYCLES(16'h0190)) u_fsr_device (.CLK_I(clk), .RESETN_I(rst_n),
        .LINK(u_fsr_link_if), .STATUS_O(st), .NV_CONFIG_O(nv), .DUMMY_CYCLES_O(dum),
        .DUMMY_DEFAULT_O(dflt), .EXEC_IN_PLACE_MODE_O(xmode), .EXEC_IN_PLACE_EN_O(xip_en),
        .DRIVE_CODE_O(drv), .HOLD_RESET_EN_O(hold), .PROTOCOL_O(proto),
        .OP_ACCEPT_O(acc), .OP_REFUSED_O(refd));
    fsr_link_asserts u_fsr_link_asserts (.CLK_I(clk), .RESETN_I(rst_n),
        .sck(u_fsr_link_if.sck), .cs_n(u_fsr_link_if.cs_n), .mosi(u_fsr_link_if.mosi),
        .miso(u_fsr_link_if.miso), .wp_n(u_fsr_link_if.wp_n));

    initial begin
        forever #5 clk = ~clk;
    end

    // Event pulses stand one cycle only, so they are tallied at every falling edge.
    always @(negedge clk) begin
        if (acc === 1'b1) acc_cnt++;
        if (refd === 1'b1) ref_cnt++;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic hang(input string name);
        num_errors++;
        $display("MISMATCH %s expected completion seen timeout", name);
        wrap_up();
    endtask : hang

    task automatic do_cmd(input logic [7:0] o, input logic [2:0] tl, input logic [31:0] td,
                          input logic [1:0] rl);
        int n;
        n = 0;
        @(negedge clk);
        while (ready !== 1'b1) begin
            n++;
            if (n > 100) hang("ready");
            @(negedge clk);
        end
        valid = 1'b1;
        op = o;
        txl = tl;
        txd = td;
        rxl = rl;
        @(negedge clk);
        valid = 1'b0;
        n = 0;
        while (done !== 1'b1) begin
            n++;
            if (n > 1500) hang("done");
            @(negedge clk);
        end
    endtask : do_cmd

    // A write needs the latch set first, so each write goes out as a pair of frames.
    task automatic wr(input logic [7:0] o, input logic [2:0] tl, input logic [31:0] td);
        do_cmd(OP_WREN, 3'h0, 32'h0, 2'h0);
        do_cmd(o, tl, td, 2'h0);
    endtask : wr

    task automatic wait_idle;
        int n;
        n = 0;
        while (st[SR_WIP] !== 1'b0) begin
            n++;
            if (n > 500) hang("busy");
            @(negedge clk);
        end
        chk("latch after busy", 32'h0, st[SR_WEL]);
    endtask : wait_idle

    task automatic t_defaults;
        chk("status", 32'h0, st);
        chk("config", 32'hffff, nv);
        chk("dummy default", 32'h1, dflt);
        chk("dummy code", 32'hf, dum);
        chk("xip enable", 32'h0, xip_en);
        chk("xip mode", 32'h7, xmode);
        chk("drive", 32'h7, drv);
        chk("hold", 32'h1, hold);
        chk("protocol", 32'(PROTO_EXT), proto);
        do_cmd(OP_RDNV, 3'h0, 32'h0, 2'h2);
        chk("config read", 32'hffff, rx);
    endtask : t_defaults

    task automatic t_latch;
        do_cmd(OP_WRSR, 3'h1, 32'h9c00_0000, 2'h0);
        chk("write without latch", 32'h0, st);
        do_cmd(OP_WREN, 3'h0, 32'h0, 2'h0);
        do_cmd(OP_RDSR, 3'h0, 32'h0, 2'h1);
        chk("status read", 32'h02, rx[7:0]);
        do_cmd(OP_WRDI, 3'h0, 32'h0, 2'h0);
        chk("latch cleared", 32'h0, st[SR_WEL]);
    endtask : t_latch

    task automatic t_protect;
        wr(OP_WRSR, 3'h1, 32'h9c00_0000);
        chk("busy after write", 32'h1, st[SR_WIP]);
        wait_idle();
        chk("status written", 32'h9c, st);
        wp = 1'b0;
        wr(OP_WRSR, 3'h1, 32'h0);
        chk("locked status", 32'h27, st[7:2]);
        chk("lock without busy", 32'h0, st[SR_WIP]);
        do_cmd(OP_PROG, 3'h4, 32'h7f00_00a5, 2'h0);
        chk("top refused", 32'h1, ref_cnt);
        do_cmd(OP_PROG, 3'h4, 32'h0000_00a5, 2'h0);
        chk("bottom accepted", 32'h1, acc_cnt);
        wait_idle();
        wr(OP_BULK, 3'h0, 32'h0);
        chk("bulk refused", 32'h2, ref_cnt);
        wp = 1'b1;
        wr(OP_WRSR, 3'h1, 32'hbc00_0000);
        wait_idle();
        chk("unlocked write", 32'hbc, st);
        wr(OP_SECT, 3'h3, 32'h0000_0000);
        chk("bottom refused", 32'h3, ref_cnt);
        do_cmd(OP_SECT, 3'h3, 32'h7f00_0000, 2'h0);
        chk("top accepted", 32'h2, acc_cnt);
        wait_idle();
        wr(OP_WRSR, 3'h1, 32'h0);
        wait_idle();
        wr(OP_BULK, 3'h0, 32'h0);
        chk("bulk accepted", 32'h3, acc_cnt);
        wait_idle();
    endtask : t_protect

    // The busy window outlasts two short frames, so a write opcode sent in it must be dropped.
    task automatic t_busy;
        wr(OP_WRSR, 3'h1, 32'h0);
        do_cmd(OP_WRDI, 3'h0, 32'h0, 2'h0);
        chk("dropped while busy", 32'h1, st[SR_WEL]);
        do_cmd(OP_RDSR, 3'h0, 32'h0, 2'h1);
        chk("busy status read", 32'h03, rx[7:0]);
        wait_idle();
        do_cmd(OP_WREN, 3'h0, 32'h0, 2'h0);
        do_cmd(OP_WRSR, 3'h2, 32'h9c9c_0000, 2'h0);
        chk("wrong byte count", 32'h02, st);
    endtask : t_busy

    task automatic t_config;
        wr(OP_WRNV, 3'h2, 32'h6330_0000);
        chk("busy on config", 32'h1, st[SR_WIP]);
        wait_idle();
        chk("config written", 32'h3063, nv);
        chk("working unchanged", 32'(PROTO_EXT), proto);
        do_cmd(OP_RDNV, 3'h0, 32'h0, 2'h2);
        chk("config order", 32'h6330, rx);
        wr(OP_WRSR, 3'h1, 32'h9c00_0000);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk("status in reset", 32'h0, st);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("config after power", 32'hffff, nv);
        chk("dummy after power", 32'h1, dflt);
    endtask : t_config

    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_defaults();
        t_latch();
        t_protect();
        t_busy();
        t_config();
        wrap_up();
    end
endmodule : flash_status_and_nv_config_regs_tb_top

// File: fsr_device.sv
// Flash end: status register, power-on configuration register and command decoder.
// How it works
// - Status bit 7 enables hardware write blocking.
// - Bit 7 with protect pin low blocks status register writes.
// - Raising protect pin or reset leaves protection.
// - Status bit 5 picks top or bottom region.
// - Block-protect bits refuse program/erase in region.
// - Bulk erase only when no block protected.
// - Write latch clear at power-up; needed first.
// - Bit 0 shows busy during write cycles.
// - Latch and busy cleared at reset.
// - Status read and written by commands.
// - Config bits 15:12 give dummy cycle count.
// - Dummy codes 0000 and 1111 mean default.
// - Config bits 11:9 select execute-in-place mode.
// - Config bits 8:6 hold drive-strength code.
// - Config bit 4 enables hold/reset function.
// - Bits 3, 2 enable quad, dual (low).
// - Power-on restores config to ones, so written values never applied; dedicated commands.
// - Config register starts as all ones.
// - Host sets dummy count for its clock.
// - Both protocol bits low means quad.
// - Working config loaded from register at reset.
module fsr_device #(
    parameter logic [15:0] BUSY_CYCLES = fsr_pkg::BUSY_CYC_DFLT
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // Link
    fsr_link_if.device LINK,
    // Register contents
    output logic [7:0] STATUS_O,
    output logic [15:0] NV_CONFIG_O,
    // Working configuration
    output logic [3:0] DUMMY_CYCLES_O,
    output logic DUMMY_DEFAULT_O,
    output logic [2:0] EXEC_IN_PLACE_MODE_O,
    output logic EXEC_IN_PLACE_EN_O,
    output logic [2:0] DRIVE_CODE_O,
    output logic HOLD_RESET_EN_O,
    output fsr_pkg::fsr_proto_e PROTOCOL_O,
    // Array operation events
    output logic OP_ACCEPT_O,
    output logic OP_REFUSED_O
);
    import fsr_pkg::*;

    typedef enum logic [2:0] {
        ST_OPC = 3'b000,
        ST_COLLECT = 3'b001,
        ST_READ_SR = 3'b010,
        ST_READ_NV = 3'b011,
        ST_DROP = 3'b100
    } fsr_dst_e;

    typedef struct packed {
        logic [1:0] sck_s;
        logic [1:0] cs_s;
        logic [1:0] mosi_s;
        logic [1:0] wp_s;
        logic sck_prev;
        logic cs_prev;
        fsr_dst_e st;
        logic [2:0] bit_cnt;
        logic [7:0] rx;
        logic [2:0] byte_cnt;
        logic [7:0] op;
        logic [31:0] data;
        logic [23:0] addr;
        logic [15:0] tx;
        logic miso;
        logic [7:0] sr;
        logic [15:0] nv;
        logic [15:0] cfg;
        logic load;
        logic dummy_def;
        logic xip_en;
        fsr_proto_e proto;
        logic [15:0] busy_cnt;
        logic accept;
        logic refuse;
    } fsr_dev_s;

    localparam fsr_dev_s DEV_RST = '{
        cs_s: 2'b11,
        wp_s: 2'b11,
        cs_prev: 1'b1,
        st: ST_OPC,
        sr: SR_RESET,
        nv: NV_FACTORY,
        cfg: NV_FACTORY,
        load: 1'b1,
        dummy_def: 1'b1,
        proto: PROTO_EXT,
        default: '0
    };

    fsr_dev_s q;
    fsr_dev_s n;

    // Region size doubles per block-protect step, capped at the whole array.
    function automatic logic prot_hit(input logic [7:0] sr, input logic [23:0] addr);
        logic [3:0] bp;
        logic [7:0] cnt;
        logic [7:0] sect;
        bp = {sr[SR_BP3], sr[SR_BP_LO +: 3]};
        sect = {1'b0, addr[SECT_MSB:SECT_LSB]};
        cnt = (bp > 4'h8) ? SECTORS : 8'(9'h001 << (bp - 4'h1));
        if (bp == 4'h0) begin
            prot_hit = 1'b0;
        end else if (sr[SR_TB]) begin
            prot_hit = sect < cnt;
        end else begin
            prot_hit = sect >= (SECTORS - cnt);
        end
    endfunction : prot_hit

    always_comb begin
        logic rise;
        logic fall;
        logic cs_end;
        logic hw_prot;
        logic [7:0] rx_byte;
        rise = 1'b0;
        fall = 1'b0;
        cs_end = 1'b0;
        hw_prot = 1'b0;
        rx_byte = 8'h00;
        n = q;
        n.sck_s = {q.sck_s[0], LINK.sck};
        n.cs_s = {q.cs_s[0], LINK.cs_n};
        n.mosi_s = {q.mosi_s[0], LINK.mosi};
        n.wp_s = {q.wp_s[0], LINK.wp_n};
        n.sck_prev = q.sck_s[1];
        n.cs_prev = q.cs_s[1];
        n.accept = 1'b0;
        n.refuse = 1'b0;
        rise = q.sck_s[1] & ~q.sck_prev;
        fall = ~q.sck_s[1] & q.sck_prev;
        cs_end = q.cs_s[1] & ~q.cs_prev;
        hw_prot = q.sr[SR_WRDIS] & ~q.wp_s[1];
        // The working copy only changes here, and reset first returns the register to ones, so a config write never reaches it.
        if (q.load) begin
            n.load = 1'b0;
            n.cfg = q.nv;
            n.dummy_def = (q.nv[NV_DUMMY_LSB +: 4] == DUMMY_DFLT_A)
                || (q.nv[NV_DUMMY_LSB +: 4] == DUMMY_DFLT_B);
            n.xip_en = q.nv[NV_XIP_LSB +: 3] != XIP_OFF;
            if (!q.nv[NV_QUAD_N]) begin
                n.proto = PROTO_QUAD;
            end else if (!q.nv[NV_DUAL_N]) begin
                n.proto = PROTO_DUAL;
            end else begin
                n.proto = PROTO_EXT;
            end
        end
        if (q.sr[SR_WIP]) begin
            n.busy_cnt = q.busy_cnt - 16'h0001;
            if (q.busy_cnt == 16'h0001) begin
                n.sr[SR_WIP] = 1'b0;
                n.sr[SR_WEL] = 1'b0;
            end
        end
        if (q.cs_s[1]) begin
            n.st = ST_OPC;
            n.bit_cnt = 3'h0;
            n.byte_cnt = 3'h0;
            // Commands act only once the frame closes on a byte boundary.
            if (cs_end && q.st == ST_COLLECT && q.bit_cnt == 3'h0 && !q.sr[SR_WIP]) begin
                if (q.op == OP_WREN && q.byte_cnt == 3'h0) begin
                    n.sr[SR_WEL] = 1'b1;
                end else if (q.op == OP_WRDI && q.byte_cnt == 3'h0) begin
                    n.sr[SR_WEL] = 1'b0;
                end else if (q.op == OP_WRSR && q.byte_cnt == 3'h1 && q.sr[SR_WEL]) begin
                    if (!hw_prot) begin
                        n.sr = (q.sr & ~SR_NV_MASK) | (q.data[7:0] & SR_NV_MASK);
                        n.sr[SR_WIP] = 1'b1;
                        n.busy_cnt = BUSY_CYCLES;
                    end
                end else if (q.op == OP_WRNV && q.byte_cnt == 3'h2 && q.sr[SR_WEL]) begin
                    n.nv = {q.data[7:0], q.data[15:8]};
                    n.sr[SR_WIP] = 1'b1;
                    n.busy_cnt = BUSY_CYCLES;
                end else if (q.sr[SR_WEL] && ((q.op == OP_PROG && q.byte_cnt >= 3'h4)
                        || (q.op == OP_SECT && q.byte_cnt == 3'h3)
                        || (q.op == OP_BULK && q.byte_cnt == 3'h0))) begin
                    if (q.op == OP_BULK ? (q.sr[SR_BP3] | (|q.sr[SR_BP_LO +: 3]))
                            : prot_hit(q.sr, q.addr)) begin
                        n.refuse = 1'b1;
                    end else begin
                        n.accept = 1'b1;
                        n.sr[SR_WIP] = 1'b1;
                        n.busy_cnt = BUSY_CYCLES;
                    end
                end
            end
        end else begin
            if (fall) begin
                n.miso = q.tx[15];
                n.tx = {q.tx[14:0], 1'b0};
            end
            if (rise) begin
                rx_byte = {q.rx[6:0], q.mosi_s[1]};
                n.rx = rx_byte;
                n.bit_cnt = q.bit_cnt + 3'h1;
                if (q.bit_cnt == 3'h7) begin
                    case (q.st)
                        ST_OPC: begin
                            n.op = rx_byte;
                            if (rx_byte == OP_RDSR) begin
                                n.st = ST_READ_SR;
                                n.tx = {q.sr, 8'h00};
                            end else if (q.sr[SR_WIP]) begin
                                n.st = ST_DROP;
                            end else if (rx_byte == OP_RDNV) begin
                                n.st = ST_READ_NV;
                                n.tx = {q.nv[7:0], q.nv[15:8]};
                            end else if (rx_byte == OP_WREN || rx_byte == OP_WRDI
                                    || rx_byte == OP_WRSR || rx_byte == OP_WRNV
                                    || rx_byte == OP_PROG || rx_byte == OP_SECT
                                    || rx_byte == OP_BULK) begin
                                n.st = ST_COLLECT;
                            end else begin
                                n.st = ST_DROP;
                            end
                        end
                        ST_COLLECT: begin
                            n.data = {q.data[23:0], rx_byte};
                            if (q.byte_cnt == 3'h2) begin
                                n.addr = {q.data[15:0], rx_byte};
                            end
                            if (q.byte_cnt != 3'h7) begin
                                n.byte_cnt = q.byte_cnt + 3'h1;
                            end
                        end
                        ST_READ_SR: begin
                            n.tx = {q.sr, 8'h00};
                        end
                        default: begin
                            n.st = q.st;
                        end
                    endcase
                end
            end
        end
    end

    // Power-on is modelled by this reset, so volatile bits clear and config returns to ones.
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            q <= DEV_RST;
        end else begin
            q <= n;
        end
    end

    assign LINK.miso = q.miso;
    assign STATUS_O = q.sr;
    assign NV_CONFIG_O = q.nv;
    assign DUMMY_CYCLES_O = q.cfg[NV_DUMMY_LSB +: 4];
    assign DUMMY_DEFAULT_O = q.dummy_def;
    assign EXEC_IN_PLACE_MODE_O = q.cfg[NV_XIP_LSB +: 3];
    assign EXEC_IN_PLACE_EN_O = q.xip_en;
    assign DRIVE_CODE_O = q.cfg[NV_DRV_LSB +: 3];
    assign HOLD_RESET_EN_O = q.cfg[NV_HOLD];
    assign PROTOCOL_O = q.proto;
    assign OP_ACCEPT_O = q.accept;
    assign OP_REFUSED_O = q.refuse;
endmodule : fsr_device

// File: fsr_host.sv
// Controller end: frames one command on the serial link and returns read bytes.
module fsr_host (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // Command request
    input wire logic CMD_VALID_I,
    input wire logic [7:0] CMD_OP_I,
    input wire logic [2:0] CMD_TXLEN_I,
    input wire logic [31:0] CMD_TXDATA_I,
    input wire logic [1:0] CMD_RXLEN_I,
    input wire logic WP_LEVEL_I,
    // Command answer
    output logic CMD_READY_O,
    output logic DONE_O,
    output logic [15:0] RX_DATA_O,
    // Link
    fsr_link_if.host LINK
);
    import fsr_pkg::*;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_LOW = 2'b01,
        HS_HIGH = 2'b10,
        HS_GAP = 2'b11
    } fsr_hst_e;

    typedef struct packed {
        fsr_hst_e st;
        logic [3:0] div;
        logic [5:0] bits;
        logic [39:0] sr;
        logic [15:0] rx;
        logic [1:0] miso_s;
        logic sck;
        logic cs_n;
        logic mosi;
        logic wp_n;
        logic ready;
        logic done;
        logic [15:0] rx_out;
    } fsr_host_s;

    localparam logic [3:0] HALF_LAST = 4'(LINK_HALF_CYC - 1);
    localparam fsr_host_s HOST_RST = '{st: HS_IDLE, cs_n: 1'b1, wp_n: 1'b1, default: '0};

    fsr_host_s q;
    fsr_host_s n;

    always_comb begin
        logic half;
        half = q.div == HALF_LAST;
        n = q;
        n.miso_s = {q.miso_s[0], LINK.miso};
        n.wp_n = WP_LEVEL_I;
        n.done = 1'b0;
        n.div = half ? 4'h0 : q.div + 4'h1;
        case (q.st)
            HS_IDLE: begin
                n.div = 4'h0;
                if (CMD_VALID_I && q.ready) begin
                    // Write commands are only honoured after a separate enable frame.
                    n.sr = {CMD_OP_I, CMD_TXDATA_I};
                    n.bits = 6'((32'(CMD_TXLEN_I) + 32'(CMD_RXLEN_I) + 1) * 8);
                    n.cs_n = 1'b0;
                    n.mosi = CMD_OP_I[7];
                    n.ready = 1'b0;
                    n.st = HS_LOW;
                end else begin
                    n.ready = 1'b1;
                end
            end
            HS_LOW: begin
                if (half) begin
                    n.sck = 1'b1;
                    n.rx = {q.rx[14:0], q.miso_s[1]};
                    n.st = HS_HIGH;
                end
            end
            HS_HIGH: begin
                if (half) begin
                    n.sck = 1'b0;
                    n.bits = q.bits - 6'h01;
                    if (q.bits == 6'h01) begin
                        n.st = HS_GAP;
                    end else begin
                        n.sr = {q.sr[38:0], 1'b0};
                        n.mosi = q.sr[38];
                        n.st = HS_LOW;
                    end
                end
            end
            default: begin
                if (half) begin
                    if (!q.cs_n) begin
                        n.cs_n = 1'b1;
                        n.mosi = 1'b0;
                    end else begin
                        n.st = HS_IDLE;
                        n.done = 1'b1;
                        n.rx_out = q.rx;
                        n.ready = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            q <= HOST_RST;
        end else begin
            q <= n;
        end
    end

    assign LINK.sck = q.sck;
    assign LINK.cs_n = q.cs_n;
    assign LINK.mosi = q.mosi;
    assign LINK.wp_n = q.wp_n;
    assign CMD_READY_O = q.ready;
    assign DONE_O = q.done;
    assign RX_DATA_O = q.rx_out;
endmodule : fsr_host

// File: fsr_link_asserts.sv
// Checker for the serial link wires between the controller end and the flash end.
module fsr_link_asserts (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // Link wires
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic wp_n
);
    logic [2:0] bit_q;

    // Counts link clock rises modulo eight so that a frame ending mid-byte is caught.
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            bit_q <= 3'h0;
        end else if (cs_n) begin
            bit_q <= 3'h0;
        end else if ($rose(sck)) begin
            bit_q <= bit_q + 3'h1;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("link clock high outside a frame");
    a_cs_setup_time: assert property ($fell(cs_n) |-> !sck [*6] ##[1:4] sck)
        else $error("select setup before first clock wrong");
    a_sck_high_time: assert property ($rose(sck) |-> sck [*6] ##[1:4] !sck)
        else $error("link clock high phase wrong");
    a_sck_low_time: assert property ($fell(sck) && !cs_n |-> !sck [*6])
        else $error("link clock low phase too short");
    a_mosi_stable_high: assert property (sck |-> $stable(mosi))
        else $error("command line moved while link clock high");
    a_miso_stable_high: assert property (sck && !cs_n |-> $stable(miso))
        else $error("reply line moved while link clock high");
    a_cs_tail_gap: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("gap between frames too short");
    a_frame_whole_bytes: assert property ($rose(cs_n) |-> bit_q == 3'h0)
        else $error("frame did not end on a byte boundary");
    c_frame_done: cover property ($rose(cs_n));
endmodule : fsr_link_asserts

// File: fsr_link_if.sv
// Serial link wires between the flash controller and the flash register device.
interface fsr_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    logic wp_n;
    modport host (output sck, output cs_n, output mosi, output wp_n, input miso);
    modport device (input sck, input cs_n, input mosi, input wp_n, output miso);
endinterface : fsr_link_if

// File: fsr_pkg.sv
// Shared constants, command codes and types for the flash status and configuration link.
package fsr_pkg;
    // Command codes.
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_RDNV = 8'hb5;
    localparam logic [7:0] OP_WRNV = 8'hb1;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_SECT = 8'hd8;
    localparam logic [7:0] OP_BULK = 8'hc7;
    // Status bit positions.
    localparam int SR_WRDIS = 7;
    localparam int SR_BP3 = 6;
    localparam int SR_TB = 5;
    localparam int SR_BP_LO = 2;
    localparam int SR_WEL = 1;
    localparam int SR_WIP = 0;
    localparam logic [7:0] SR_NV_MASK = 8'hfc;
    localparam logic [7:0] SR_RESET = 8'h00;
    // Power-on configuration field positions and values.
    localparam int NV_DUMMY_LSB = 12;
    localparam int NV_XIP_LSB = 9;
    localparam int NV_DRV_LSB = 6;
    localparam int NV_HOLD = 4;
    localparam int NV_QUAD_N = 3;
    localparam int NV_DUAL_N = 2;
    localparam logic [15:0] NV_FACTORY = 16'hffff;
    localparam logic [3:0] DUMMY_DFLT_A = 4'h0;
    localparam logic [3:0] DUMMY_DFLT_B = 4'hf;
    localparam logic [2:0] XIP_OFF = 3'h7;
    // Array geometry: 64 KB sectors, 23-bit byte address.
    localparam int SECT_MSB = 22;
    localparam int SECT_LSB = 16;
    localparam logic [7:0] SECTORS = 8'h80;
    // Timing.
    localparam int CLK_MHZ = 100;
    localparam int LINK_HALF_NS = 80;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] BUSY_CYC_DFLT = 16'h03e8;
    typedef enum logic [1:0] {
        PROTO_EXT = 2'b00,
        PROTO_DUAL = 2'b01,
        PROTO_QUAD = 2'b10
    } fsr_proto_e;
endpackage : fsr_pkg
